// ---- src/raf_top.sv ----
// Receive destination address filter and wake-up frame detector
// Function
// RULE1 - All controls clear: perfect match only
// RULE2 - Hash-perfect: physical perfect, multicast hashed
// RULE3 - Hash-only plus hash-perfect: everything hashed
// RULE4 - Inverse: accept only non-matching addresses
// RULE5 - Promiscuous accepts every frame, broadcasts too
// RULE6 - Multicast pass: all multicast, physical filtered
// RULE7 - First transmitted bit marks multicast
// RULE8 - Station address is high:low concatenation
// RULE9 - Two hash registers form 64-bit table
// RULE10 - Six address bits index the hash table
// RULE11 - Failing frames are dropped, not passed
// RULE12 - Wake enable stops normal reception
// RULE13 - Wake hit sets status, optional irq/power
// RULE14 - Clearing wake enable resumes reception
// RULE15 - Host loads filters before enabling wake
// RULE16 - Loader index resets, eight writes fill
// RULE17 - Four filters: address check plus CRC
// RULE18 - 31-bit byte mask selects CRC bytes
// RULE19 - Host keeps pattern offset beyond 12
// RULE20 - Broadcast wake frames ignore broadcast disable
// RULE21 - Wake mode checks all frames for host
// RULE22 - Fixed layout of the eight dwords
// RULE23 - Command bit0 enables, bit3 picks multicast
// RULE24 - CRC equal to programmed value wakes
// RULE25 - CRC-16 0x8005 from all ones
// RULE26 - Unlisted control mixes fall back to perfect
//
// Register access over APB and the placing of the registers were decided locally.
`default_nettype none
module raf_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [raf_pkg::RAF_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic rx_frame,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	output logic filt_pass,
	output logic filt_drop,
	output logic host_irq,
	output logic power_event_signal
);
	import raf_pkg::*;

	// ************************************************************
	// Registers
	// ************************************************************
	logic [31:0] mac_control_reg;
	logic [31:0] station_address_high;
	logic [31:0] station_address_low;
	logic [31:0] hash_table_high;
	logic [31:0] hash_table_low;
	logic [31:0] wake_control_status_reg;
	logic [31:0] wake_dw [RAF_DW_NUM];
	logic [2:0] load_idx;
	logic [31:0] next_rdata;
	logic next_err;
	logic wr_en;
	logic wake_hit;

	assign wr_en = psel && penable && pready && pwrite;

	always_comb begin
		next_err = 1'b0;
		case (paddr)
		RAF_MAC_CTRL: next_rdata = mac_control_reg;
		RAF_STA_HIGH: next_rdata = station_address_high;
		RAF_STA_LOW: next_rdata = station_address_low;
		RAF_HASH_HIGH: next_rdata = hash_table_high;
		RAF_HASH_LOW: next_rdata = hash_table_low;
		RAF_WAKE_CSR: next_rdata = wake_control_status_reg;
		RAF_WAKE_LOAD: next_rdata = RAF_REG_RST;
		default: begin
			next_rdata = RAF_REG_RST;
			next_err = 1'b1;
		end
		endcase
	end

	// Answer in the first access cycle: pready is raised by setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= RAF_REG_RST;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			prdata <= (psel && !penable && !pwrite) ? next_rdata :
				RAF_REG_RST;
			pslverr <= psel && !penable && next_err;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mac_control_reg <= RAF_REG_RST;
			station_address_high <= RAF_REG_RST;
			station_address_low <= RAF_REG_RST;
			hash_table_high <= RAF_REG_RST;
			hash_table_low <= RAF_REG_RST;
		end else if (wr_en) begin
			case (paddr)
			RAF_MAC_CTRL: begin
				mac_control_reg <= pwdata;
				// Soft reset is a strobe, never stored
				mac_control_reg[RAF_CR_SOFT_RST] <= 1'b0;
			end
			RAF_STA_HIGH: station_address_high <= pwdata;
			RAF_STA_LOW: station_address_low <= pwdata;
			RAF_HASH_HIGH: hash_table_high <= pwdata;
			RAF_HASH_LOW: hash_table_low <= pwdata;
			default: begin
			end
			endcase
		end
	end

	// Received flag: a hit in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_control_status_reg <= RAF_REG_RST;
		end else begin
			if (wr_en && paddr == RAF_WAKE_CSR) begin
				wake_control_status_reg[RAF_WK_ENABLE] <=
					pwdata[RAF_WK_ENABLE]; // RULE12 RULE14
				wake_control_status_reg[RAF_WK_IRQ_EN] <=
					pwdata[RAF_WK_IRQ_EN];
				wake_control_status_reg[RAF_WK_PWR_EN] <=
					pwdata[RAF_WK_PWR_EN];
				if (pwdata[RAF_WK_RCVD]) begin
					wake_control_status_reg[RAF_WK_RCVD] <= 1'b0;
				end
			end
			if (wake_hit) begin
				wake_control_status_reg[RAF_WK_RCVD] <= 1'b1; // RULE13
			end
		end
	end

	// Write-only loader walks the eight dwords and wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_idx <= 3'h0;
			for (int i = 0; i < RAF_DW_NUM; i++) begin
				wake_dw[i] <= RAF_REG_RST;
			end
		end else if (wr_en && paddr == RAF_MAC_CTRL &&
			pwdata[RAF_CR_SOFT_RST]) begin
			load_idx <= 3'h0; // RULE16
		end else if (wr_en && paddr == RAF_WAKE_LOAD) begin
			wake_dw[load_idx] <= pwdata; // RULE16 RULE22
			load_idx <= load_idx + 3'h1; // RULE16
		end
	end

	// ************************************************************
	// Frame tracking and destination address capture
	// ************************************************************
	logic rx_frame_q;
	logic frame_start;
	logic frame_end;
	logic [RAF_POS_W-1:0] pos;
	logic [RAF_DA_W-1:0] da;
	logic da_done;

	assign frame_start = rx_frame && !rx_frame_q;
	assign frame_end = !rx_frame && rx_frame_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_frame_q <= 1'b0;
			pos <= '0;
			da <= '0;
			da_done <= 1'b0;
		end else begin
			rx_frame_q <= rx_frame;
			da_done <= rx_frame_q && rx_byte_valid &&
				pos == RAF_POS_W'(RAF_DA_BYTES - 1);
			if (frame_start) begin
				pos <= '0;
			end else if (rx_frame_q && rx_byte_valid) begin
				if (pos < RAF_POS_W'(RAF_DA_BYTES)) begin
					da <= {da[RAF_DA_W-9:0], rx_byte};
				end
				if (pos != '1) begin
					pos <= pos + RAF_POS_W'(1);
				end
			end
		end
	end

	// ************************************************************
	// Address filter
	// ************************************************************
	logic [RAF_DA_W-1:0] station;
	logic [63:0] hash_table;
	logic [RAF_HASH_IDX_W-1:0] hash_idx;
	logic is_mcast;
	logic is_broadcast_disable;
	logic perfect_hit;
	logic hash_hit;
	logic promiscuous_accept, mcp, inv, ho, hp, bdis;
	logic addr_ok;
	logic next_accept;
	logic wake_en;
	logic wake_addr_ok;
	logic frame_mcast;

	assign promiscuous_accept = mac_control_reg[RAF_CR_PROMISC];
	assign mcp = mac_control_reg[RAF_CR_MULTI_PASS];
	assign inv = mac_control_reg[RAF_CR_INVERSE];
	assign ho = mac_control_reg[RAF_CR_HASH_ONLY];
	assign hp = mac_control_reg[RAF_CR_HASH_PERF];
	assign bdis = mac_control_reg[RAF_CR_BROAD_DIS];
	assign wake_en = wake_control_status_reg[RAF_WK_ENABLE];

	// First received byte is the top byte of da
	assign station = {station_address_high[RAF_STA_HIGH_W-1:0],
		station_address_low}; // RULE8
	assign hash_table = {hash_table_high, hash_table_low}; // RULE9
	assign hash_idx = da[RAF_DA_W-1 -: RAF_HASH_IDX_W]; // RULE10
	assign hash_hit = hash_table[hash_idx]; // RULE10
	assign is_mcast = da[RAF_MCAST_BIT]; // RULE7
	assign is_broadcast_disable = &da;
	assign perfect_hit = da == station;

	always_comb begin
		addr_ok = perfect_hit; // RULE1 RULE26
		if (promiscuous_accept) begin
			addr_ok = 1'b1; // RULE5
		end else if (inv && !mcp && !ho && !hp) begin
			addr_ok = !perfect_hit; // RULE4
		end else if (mcp && !inv && (!ho || hp)) begin
			addr_ok = is_mcast || (ho ? hash_hit : perfect_hit); // RULE6
		end else if (!mcp && !inv && hp) begin
			addr_ok = (ho || is_mcast) ? hash_hit : perfect_hit; // RULE2 RULE3
		end
		next_accept = addr_ok && !(bdis && is_broadcast_disable && !promiscuous_accept);
	end

	// Decision leaves one cycle after the address is complete
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filt_pass <= 1'b0;
			filt_drop <= 1'b0;
			wake_addr_ok <= 1'b0;
			frame_mcast <= 1'b0;
		end else begin
			filt_pass <= da_done && !wake_en && next_accept; // RULE12
			filt_drop <= da_done && (wake_en || !next_accept); // RULE11
			if (frame_start) begin
				wake_addr_ok <= 1'b0;
			end else if (da_done) begin
				// Broadcast disable does not gate wake frames
				wake_addr_ok <= addr_ok; // RULE20 RULE21
				frame_mcast <= is_mcast;
			end
		end
	end

	// ************************************************************
	// Wake-up filters
	// ************************************************************
	logic [15:0] crc_q [RAF_FILTERS];
	logic [RAF_FILTERS-1:0] pat_hit;

	for (genvar g = 0; g < RAF_FILTERS; g++) begin : g_flt
		logic [7:0] cmd;
		logic [15:0] want;
		assign cmd = wake_dw[RAF_DW_CMD][8*g +: 8]; // RULE22
		assign want = wake_dw[RAF_DW_CRC_LO + g/2][16*(g%2) +: 16];
		raf_wake_crc #(.POS_W(RAF_POS_W)) u_crc (
			.pclk(pclk),
			.presetn(presetn),
			.clear(frame_start),
			.byte_valid(rx_frame_q && rx_byte_valid),
			.byte_data(rx_byte),
			.pos(pos),
			.mask(wake_dw[g][RAF_MASK_W-1:0]),
			.offset(wake_dw[RAF_DW_OFF][8*g +: 8]),
			.crc(crc_q[g])
		);
		assign pat_hit[g] = cmd[RAF_CMD_EN] &&
			cmd[RAF_CMD_MCAST] == frame_mcast &&
			crc_q[g] == want; // RULE17 RULE23 RULE24
	end

	assign wake_hit = frame_end && wake_en && wake_addr_ok &&
		|pat_hit; // RULE17 RULE21

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_irq <= 1'b0;
			power_event_signal <= 1'b0;
		end else begin
			host_irq <= wake_control_status_reg[RAF_WK_RCVD] &&
				wake_control_status_reg[RAF_WK_IRQ_EN]; // RULE13
			power_event_signal <= wake_control_status_reg[RAF_WK_RCVD] &&
				wake_control_status_reg[RAF_WK_PWR_EN]; // RULE13
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("pready missing in access cycle");
	promisc_pass_a: assert property (da_done && promiscuous_accept && !wake_en // RULE5
		|=> filt_pass)
		else $error("promiscuous frame not passed");
	wake_block_a: assert property (da_done && wake_en // RULE12
		|=> filt_drop && !filt_pass)
		else $error("frame passed during wake mode");
	perfect_only_a: assert property (da_done && !wake_en && // RULE1
		mac_control_reg[5:0] == 6'h00
		|=> filt_pass == $past(perfect_hit))
		else $error("perfect mode decision wrong");
	inverse_mode_a: assert property (da_done && !wake_en && inv && // RULE4
		!promiscuous_accept && !mcp && !ho && !hp && !bdis
		|=> filt_pass != $past(perfect_hit))
		else $error("inverse mode decision wrong");
	drop_fail_a: assert property (da_done && !next_accept // RULE11
		|=> !filt_pass && filt_drop)
		else $error("failing frame not dropped");
	loader_wrap_a: assert property (wr_en && // RULE16
		paddr == RAF_WAKE_LOAD && load_idx == 3'h7 |=> load_idx == 3'h0)
		else $error("loader index did not wrap");
	wake_flag_a: assert property (wake_hit // RULE13
		|=> wake_control_status_reg[RAF_WK_RCVD] ##1
		host_irq == wake_control_status_reg[RAF_WK_IRQ_EN])
		else $error("wake status or irq missing");
	// Outside wake mode an accepted frame must reach the host again
	wake_exit_a: assert property (da_done && !wake_en && next_accept // RULE14
		|=> filt_pass && !filt_drop)
		else $error("frame not passed outside wake mode");

	pass_seen_c: cover property (filt_pass);
	wake_seen_c: cover property (wake_hit);
	hash_pass_c: cover property (da_done && hp && is_mcast ##1 filt_pass);
	load_full_c: cover property (wr_en && paddr == RAF_WAKE_LOAD &&
		load_idx == 3'h7);
endmodule
`default_nettype wire

// ---- src/raf_pkg.sv ----
// Constants shared by the receive address and wake-up filter
`default_nettype none
package raf_pkg;
	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam int RAF_AW = 8;
	localparam logic [7:0] RAF_MAC_CTRL = 8'h00;
	localparam logic [7:0] RAF_STA_HIGH = 8'h04;
	localparam logic [7:0] RAF_STA_LOW = 8'h08;
	localparam logic [7:0] RAF_HASH_HIGH = 8'h0c;
	localparam logic [7:0] RAF_HASH_LOW = 8'h10;
	localparam logic [7:0] RAF_WAKE_CSR = 8'h14;
	localparam logic [7:0] RAF_WAKE_LOAD = 8'h18;
	localparam logic [31:0] RAF_REG_RST = 32'h0000_0000;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int RAF_CR_PROMISC = 0;
	localparam int RAF_CR_MULTI_PASS = 1;
	localparam int RAF_CR_INVERSE = 2;
	localparam int RAF_CR_HASH_ONLY = 3;
	localparam int RAF_CR_HASH_PERF = 4;
	localparam int RAF_CR_BROAD_DIS = 5;
	localparam int RAF_CR_SOFT_RST = 31;
	localparam int RAF_WK_ENABLE = 0;
	localparam int RAF_WK_RCVD = 1;
	localparam int RAF_WK_IRQ_EN = 2;
	localparam int RAF_WK_PWR_EN = 3;
	localparam int RAF_STA_HIGH_W = 16;

	// ************************************************************
	// Frame and wake-up filter layout
	// ************************************************************
	localparam int RAF_DA_BYTES = 6;
	localparam int RAF_DA_W = 48;
	localparam int RAF_MCAST_BIT = 40;
	localparam int RAF_HASH_IDX_W = 6;
	localparam int RAF_POS_W = 11;
	localparam int RAF_FILTERS = 4;
	localparam int RAF_DW_NUM = 8;
	localparam int RAF_MASK_W = 31;
	localparam int RAF_DW_CMD = 4;
	localparam int RAF_DW_OFF = 5;
	localparam int RAF_DW_CRC_LO = 6;
	localparam int RAF_DW_CRC_HI = 7;
	localparam int RAF_CMD_EN = 0;
	localparam int RAF_CMD_MCAST = 3;
	localparam logic [15:0] RAF_CRC_POLY = 16'h8005;
	localparam logic [15:0] RAF_CRC_INIT = 16'hffff;
endpackage
`default_nettype wire

// ---- src/raf_wake_crc.sv ----
// One wake-up pattern filter: masked CRC-16 over the received bytes
`default_nettype none
module raf_wake_crc #(
	parameter int POS_W = raf_pkg::RAF_POS_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	input wire logic [POS_W-1:0] pos,
	input wire logic [raf_pkg::RAF_MASK_W-1:0] mask,
	input wire logic [7:0] offset,
	output logic [15:0] crc
);
	import raf_pkg::*;

	logic [POS_W-1:0] rel;
	logic take;

	// Frame order: bit 0 of each byte enters first
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		logic fb;
		r = c;
		for (int i = 0; i < 8; i++) begin
			fb = r[15] ^ d[i];
			r = {r[14:0], 1'b0};
			if (fb) begin
				r = r ^ RAF_CRC_POLY; // RULE25
			end
		end
		return r;
	endfunction

	assign rel = pos - POS_W'(offset);
	// Byte offset+j is covered only while mask bit j is set
	assign take = byte_valid && (pos >= POS_W'(offset)) &&
		(rel < POS_W'(RAF_MASK_W)) && mask[rel[4:0]]; // RULE18

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc <= RAF_CRC_INIT;
		end else if (clear) begin
			crc <= RAF_CRC_INIT; // RULE25
		end else if (take) begin
			crc <= crc_byte(crc, byte_data); // RULE25
		end
	end
endmodule
`default_nettype wire

// ---- tb/raf_fabric_model.sv ----
// Switch fabric host port model that feeds frames to the filter
`default_nettype none
module raf_fabric_model (
	input wire logic pclk,
	output logic rx_frame,
	output logic rx_byte_valid,
	output logic [7:0] rx_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] frm [0:63];
	initial begin
		rx_frame = 1'b0;
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
	end
	// Idle data toggles so a stale byte can never pass for a fresh one
	task automatic send_frame(input int len, input int gap);
		@(posedge pclk);
		rx_frame <= 1'b1;
		for (int i = 0; i < len; i++) begin
			repeat (gap) begin
				@(posedge pclk);
				rx_byte_valid <= 1'b0;
				rx_byte <= ~rx_byte;
			end
			@(posedge pclk);
			rx_byte_valid <= 1'b1;
			rx_byte <= frm[i];
		end
		@(posedge pclk);
		rx_byte_valid <= 1'b0;
		rx_frame <= 1'b0;
		rx_byte <= ~rx_byte;
		@(posedge pclk);
		rx_byte <= ~rx_byte;
	endtask
endmodule
`default_nettype wire

// ---- tb/tb_raf_top.sv ----
// Self-checking bench for the receive address and wake-up filter
`default_nettype none
module tb_raf_top;
	timeunit 1ns;
	timeprecision 1ps;
	import raf_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ex;
	logic rx_frame, rx_byte_valid, filt_pass, filt_drop;
	logic host_irq, power_event_signal;
	logic [7:0] paddr, rx_byte;
	logic [31:0] pwdata, prdata, rd, cr;
	logic [47:0] sta, da;
	logic [63:0] ht;
	logic [15:0] crc;
	logic expq [$];
	int failures, compares;
	integer seed = 32'h697d19c1;
	logic [31:0] modes [13] = '{32'h00, 32'h10, 32'h18, 32'h04, 32'h01,
		32'h1f, 32'h21, 32'h02, 32'h12, 32'h1a, 32'h14, 32'h08, 32'h20};

	raf_top raf_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.rx_frame(rx_frame), .rx_byte_valid(rx_byte_valid),
		.rx_byte(rx_byte), .filt_pass(filt_pass), .filt_drop(filt_drop),
		.host_irq(host_irq), .power_event_signal(power_event_signal));
	raf_fabric_model raf_fabric_model_inst (.pclk(pclk),
		.rx_frame(rx_frame), .rx_byte_valid(rx_byte_valid),
		.rx_byte(rx_byte));

	initial pclk = 1'b0;
	always #20 pclk = ~pclk;

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic complete_run;
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			complete_run;
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check("prdata", rd, exp);
	endtask

	// Reference decision, written from the mode table, not the design
	function automatic logic exp_acc(logic [47:0] d);
		logic p, m, h;
		p = (d == sta);
		m = d[40];
		h = ht[d[47:42]];
		if (cr[RAF_CR_PROMISC])
			return 1'b1;
		if (cr[RAF_CR_BROAD_DIS] && &d)
			return 1'b0;
		case (cr[4:1])
			4'b1000: return m ? h : p;
			4'b1100: return h;
			4'b0010: return !p;
			4'b0001, 4'b1001: return m | p;
			4'b1101: return m | h;
			default: return p;
		endcase
	endfunction

	function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
		for (int i = 0; i < 8; i++)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? RAF_CRC_POLY : 16'h0);
		return c;
	endfunction

	task automatic prep(input logic [47:0] d);
		for (int i = 0; i < 20; i++)
			raf_fabric_model_inst.frm[i] = 8'($random(seed));
		for (int i = 0; i < 6; i++)
			raf_fabric_model_inst.frm[i] = d[47-8*i -: 8];
		crc = RAF_CRC_INIT;
		for (int i = 14; i < 18; i++)
			crc = crc_step(crc, raf_fabric_model_inst.frm[i]);
	endtask

	task automatic send(input logic e);
		expq.push_back(e);
		raf_fabric_model_inst.send_frame(20, $unsigned($random(seed)) % 3);
	endtask

	// Filter 0 looks at bytes 14..17; filters 1..3 stay disabled
	task automatic loadw(input logic [31:0] cmd);
		for (int i = 0; i < 4; i++)
			wr(RAF_WAKE_LOAD, i == 0 ? 32'hf : $random(seed) & 32'h7fffffff);
		wr(RAF_WAKE_LOAD, cmd);
		wr(RAF_WAKE_LOAD, 32'h0000_000e);
		wr(RAF_WAKE_LOAD, {16'h0, crc});
		wr(RAF_WAKE_LOAD, 32'h0);
	endtask

	always @(posedge pclk) begin
		if (filt_pass === 1'b1 || filt_drop === 1'b1) begin
			if (expq.size() == 0)
				check("spare result", 32'h1, 32'h0);
			else begin
				ex = expq.pop_front();
				check("pass drop", {filt_pass, filt_drop}, {ex, !ex});
			end
		end
	end

	initial begin
		repeat (60000) @(posedge pclk);
		failures++;
		complete_run;
	end

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a <= 8'h18; a += 4)
			rdc(8'(a), RAF_REG_RST);
		apb(1'b0, 8'h1c, 32'h0);
		check("pslverr", {31'h0, er}, 32'h1);
		sta = 48'({$random(seed), $random(seed)});
		sta[40] = 1'b0;
		wr(RAF_STA_HIGH, {16'h0, sta[47:32]});
		wr(RAF_STA_LOW, sta[31:0]);
		rdc(RAF_STA_HIGH, {16'h0, sta[47:32]});
		foreach (modes[m]) begin
			cr = modes[m];
			ht = {$random(seed), $random(seed)};
			wr(RAF_MAC_CTRL, cr);
			wr(RAF_HASH_HIGH, ht[63:32]);
			wr(RAF_HASH_LOW, ht[31:0]);
			for (int j = 0; j < 5; j++) begin
				da = 48'({$random(seed), $random(seed)});
				da[40] = (j == 3);
				da = j == 0 ? sta : j == 1 ? sta ^ 48'h1 : j == 4 ? '1 : da;
				prep(da);
				send(exp_acc(da));
			end
		end
		// Stale loader writes must be forgotten after a soft reset
		repeat (3) wr(RAF_WAKE_LOAD, 32'hffff_ffff);
		wr(RAF_MAC_CTRL, 32'h8000_0000);
		cr = 32'h0;
		wr(RAF_MAC_CTRL, cr);
		prep(sta);
		loadw(32'h01);
		wr(RAF_WAKE_CSR, 32'h0d);
		raf_fabric_model_inst.frm[15] ^= 8'h01;
		send(1'b0);
		rdc(RAF_WAKE_CSR, 32'h0d);
		raf_fabric_model_inst.frm[15] ^= 8'h01;
		raf_fabric_model_inst.frm[18] ^= 8'h01;
		send(1'b0);
		repeat (2) @(posedge pclk);
		rdc(RAF_WAKE_CSR, 32'h0f);
		check("irq", {host_irq, power_event_signal}, 32'h3);
		wr(RAF_WAKE_CSR, 32'h02);
		rdc(RAF_WAKE_CSR, 32'h00);
		// Multicast pass with broadcast disable: only the wake path sees it
		cr = 32'h22;
		wr(RAF_MAC_CTRL, cr);
		prep('1);
		loadw(32'h09);
		wr(RAF_WAKE_CSR, 32'h0d);
		send(1'b0);
		repeat (2) @(posedge pclk);
		rdc(RAF_WAKE_CSR, 32'h0f);
		wr(RAF_WAKE_CSR, 32'h02);
		cr = 32'h0;
		wr(RAF_MAC_CTRL, cr);
		prep(sta);
		send(1'b1);
		check("irq", {host_irq, power_event_signal}, 32'h0);
		for (int i = 0; i < 100 && expq.size() > 0; i++)
			@(posedge pclk);
		check("results left", 32'(expq.size()), 32'h0);
		complete_run;
	end
endmodule
`default_nettype wire
